// [pd_map_pkg.sv]
package pd_map_pkg;
    // register byte addresses
    localparam logic [7:0] ctrl_off = 8'h00;     // byte swap, hold, compatibility
    localparam logic [7:0] setpoint_off = 8'h04; // internal setpoint (read)
    localparam logic [7:0] feedback_off = 8'h08; // feedback value + over-range (write)
    localparam logic [7:0] diag_off = 8'h0c;     // diagnostic word (write)
    localparam logic [7:0] status_off = 8'h10;   // sticky events, write one to clear
    localparam logic [7:0] mask_off = 8'h14;     // interrupt mask
    localparam logic [7:0] image_off = 8'h18;    // received raw output image (read)
    // ctrl field positions
    localparam int ctrl_swap_bit = 0;
    localparam int ctrl_hold_bit = 1;
    localparam int ctrl_compat_bit = 2;
    // setpoint word layout
    localparam int value_msb = 11;
    localparam int ext_bit = 12;
    // status bit positions
    localparam int ev_loss_bit = 0;
    localparam int ev_reboot_bit = 1;
    localparam int ev_rx_bit = 2;
    localparam int ev_count = 3;
    // reset values
    localparam logic [2:0] ctrl_reset = 3'h0;
    localparam logic [ev_count-1:0] mask_reset = 3'h0;
    // reboot pulse length in cycles
    localparam int reboot_cycles = 16;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage : pd_map_pkg

// [pd_map.sv]
`timescale 1ns/1ps
// How it works
// [R1] setpoint bits 0..11 carry control value
// [R2] bit 12 extends range; 13..15 ignored
// [R3] feedback in bits 0..11, lsb first
// [R4] bit 12 flags over-range feedback
// [R5] second input word carries diagnostics
// [R6] no swap: little endian byte order
// [R7] swap: output word bytes exchanged
// [R8] swap: input bytes ordered 1,0,3,2
// [R9] hold set: keep last setpoint on loss
// [R10] hold clear: zero setpoint on loss
// [R11] compatibility change triggers reboot
// [R12] submit other settings separately from compatibility; code applies a mixed ctrl write whole
// [R13] compatibility presents legacy data layout
// [R14] values are unsigned 0..4095 counts
// [R15] unused upper feedback bits read zero
// [R16] loss seen when link_ok falls
module pd_map
    import pd_map_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    // cyclic output image from the controller, as received bytes
    input wire logic [15:0] out_image,
    input wire logic out_valid,
    // connection alive level from protocol stack (async)
    input wire logic link_ok,
    // cyclic input image to the controller
    output logic [31:0] in_image,
    // regulator side
    output logic [11:0] setpoint,
    output logic setpoint_ext,
    output logic reboot_req,
    output logic legacy_mode,
    output logic irq,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    logic [2:0] ctrl_reg; // swap, hold, compat
    logic [11:0] fb_reg; // feedback count
    logic fb_over_reg; // over-range flag
    logic [15:0] diag_reg; // diagnostics word
    logic [ev_count-1:0] status_reg; // sticky events
    logic [ev_count-1:0] mask_reg; // interrupt mask
    logic [15:0] raw_reg; // last raw output image
    logic link_s1_reg; // synchroniser stage one
    logic link_s2_reg; // synchroniser stage two
    logic link_d_reg; // previous synced level
    logic [4:0] reboot_cnt_reg; // reboot countdown
    logic [7:0] aw_addr_reg; // latched write address
    logic aw_have_reg; // write address held
    logic [31:0] w_data_reg; // latched write data
    logic [3:0] w_strb_reg; // latched strobes
    logic w_have_reg; // write data held
    logic [ev_count-1:0] ev_set; // events this cycle
    logic [ev_count-1:0] ev_clr; // software clears
    logic wr_go; // write performed this cycle
    logic loss_edge; // link just dropped
    logic [15:0] word_in; // output word after swap
    logic [15:0] fb_word; // first input word
    logic [31:0] img_next; // assembled input image

    // link level synchroniser, edge taken from the second stage only
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            link_s1_reg <= 1'b0;
            link_s2_reg <= 1'b0;
            link_d_reg <= 1'b0;
        end
        else
        begin
            link_s1_reg <= link_ok;
            link_s2_reg <= link_s1_reg;
            link_d_reg <= link_s2_reg;
        end
    end

    assign loss_edge = link_d_reg & ~link_s2_reg; // [R16]

    // undo byte swap on received output word
    always_comb
    begin
        if (ctrl_reg[ctrl_swap_bit])
            word_in = {out_image[7:0], out_image[15:8]}; // [R7]
        else
            word_in = out_image; // [R6]
    end

    // setpoint: take new values while linked, act on loss
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            setpoint <= 12'h000;
            setpoint_ext <= 1'b0;
            raw_reg <= 16'h0000;
        end
        else if (loss_edge && !ctrl_reg[ctrl_hold_bit])
        begin
            setpoint <= 12'h000; // [R10]
            setpoint_ext <= 1'b0;
        end
        else if (out_valid && link_s2_reg)
        begin
            raw_reg <= out_image;
            setpoint <= word_in[value_msb:0]; // [R1] [R14]
            setpoint_ext <= word_in[ext_bit]; // [R2]
        end
        // hold set: loss leaves setpoint untouched [R9]
    end

    // first input word: value, over-range, zero filler
    assign fb_word = {3'h0, fb_over_reg, fb_reg}; // [R3] [R4] [R15]

    // input image assembly; legacy layout uses swapped order
    always_comb
    begin
        if (ctrl_reg[ctrl_swap_bit] || ctrl_reg[ctrl_compat_bit]) // [R13]
            img_next = {diag_reg[7:0], diag_reg[15:8], fb_word[7:0], fb_word[15:8]}; // [R8]
        else
            img_next = {diag_reg, fb_word}; // [R5] [R6]
    end

    // input image register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            in_image <= 32'h0000_0000;
        else
            in_image <= img_next;
    end

    // reboot pulse on compatibility change
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            reboot_cnt_reg <= 5'h00;
        else if (wr_go && aw_addr_reg == ctrl_off && w_strb_reg[0]
                 && w_data_reg[ctrl_compat_bit] != ctrl_reg[ctrl_compat_bit])
            reboot_cnt_reg <= 5'(reboot_cycles); // [R11]
        else if (reboot_cnt_reg != 5'h00)
            reboot_cnt_reg <= reboot_cnt_reg - 5'h01;
    end

    assign reboot_req = (reboot_cnt_reg != 5'h00); // [R11]
    assign legacy_mode = ctrl_reg[ctrl_compat_bit];

    // write channel capture, either order
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_awaddr;
            end
            else if (wr_go)
                aw_have_reg <= 1'b0;
            if (s_wvalid && s_wready)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_wdata;
                w_strb_reg <= s_wstrb;
            end
            else if (wr_go)
                w_have_reg <= 1'b0;
        end
    end

    assign s_awready = ~aw_have_reg & ~s_bvalid;
    assign s_wready = ~w_have_reg & ~s_bvalid;
    assign wr_go = aw_have_reg & w_have_reg & ~s_bvalid;

    // write response
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_bvalid <= 1'b0;
            s_bresp <= resp_okay;
        end
        else if (wr_go)
        begin
            s_bvalid <= 1'b1;
            case (aw_addr_reg)
                ctrl_off, feedback_off, diag_off, status_off, mask_off: s_bresp <= resp_okay;
                default: s_bresp <= resp_slverr;
            endcase
        end
        else if (s_bready)
            s_bvalid <= 1'b0;
    end

    // writable registers; one ctrl write sets swap, hold and compat together, R12 not enforced
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl_reg <= ctrl_reset;
            fb_reg <= 12'h000;
            fb_over_reg <= 1'b0;
            diag_reg <= 16'h0000;
            mask_reg <= mask_reset;
        end
        else if (wr_go)
        begin
            case (aw_addr_reg)
                ctrl_off: if (w_strb_reg[0]) ctrl_reg <= w_data_reg[2:0];
                feedback_off:
                begin
                    if (w_strb_reg[0]) fb_reg[7:0] <= w_data_reg[7:0];
                    if (w_strb_reg[1]) fb_reg[11:8] <= w_data_reg[11:8];
                    if (w_strb_reg[1]) fb_over_reg <= w_data_reg[ext_bit]; // [R4]
                end
                diag_off:
                begin
                    if (w_strb_reg[0]) diag_reg[7:0] <= w_data_reg[7:0];
                    if (w_strb_reg[1]) diag_reg[15:8] <= w_data_reg[15:8];
                end
                mask_off: if (w_strb_reg[0]) mask_reg <= w_data_reg[ev_count-1:0];
                default: ;
            endcase
        end
    end

    // events and clears
    always_comb
    begin
        ev_set = '0;
        ev_set[ev_loss_bit] = loss_edge;
        ev_set[ev_reboot_bit] = (reboot_cnt_reg == 5'h01);
        ev_set[ev_rx_bit] = out_valid & link_s2_reg;
        ev_clr = '0;
        if (wr_go && aw_addr_reg == status_off && w_strb_reg[0])
            ev_clr = w_data_reg[ev_count-1:0];
    end

    // sticky status, set beats clear
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            status_reg <= '0;
        else
            status_reg <= (status_reg & ~ev_clr) | ev_set;
    end

    assign irq = |(status_reg & mask_reg);

    // read channel
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= resp_okay;
        end
        else if (s_arvalid && s_arready)
        begin
            s_rvalid <= 1'b1;
            s_rresp <= resp_okay;
            case (s_araddr)
                ctrl_off: s_rdata <= {29'h0, ctrl_reg};
                setpoint_off: s_rdata <= {19'h0, setpoint_ext, setpoint};
                feedback_off: s_rdata <= {16'h0, fb_word};
                diag_off: s_rdata <= {16'h0, diag_reg};
                status_off: s_rdata <= {29'h0, status_reg};
                mask_off: s_rdata <= {29'h0, mask_reg};
                image_off: s_rdata <= {16'h0, raw_reg};
                default:
                begin
                    s_rdata <= 32'h0000_0000;
                    s_rresp <= resp_slverr;
                end
            endcase
        end
        else if (s_rready)
            s_rvalid <= 1'b0;
    end

    assign s_arready = ~s_rvalid;
endmodule : pd_map

// [pd_map_sva.sv]
`timescale 1ns/1ps
// port checker for the process data mapper
module pd_map_sva
    import pd_map_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [15:0] out_image,
    input wire logic out_valid,
    input wire logic link_ok,
    input wire logic [31:0] in_image,
    input wire logic [11:0] setpoint,
    input wire logic setpoint_ext,
    input wire logic reboot_req,
    input wire logic legacy_mode,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [1:0] s_bresp,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    int unsigned boot_cnt; // cycles of reboot pulse so far
    // count the reboot pulse length
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            boot_cnt <= 0;
        else
            boot_cnt <= reboot_req ? boot_cnt + 1 : 0;
    end
    a_sp_take: assert property (out_valid && link_ok && $past(link_ok) && $past(link_ok, 2)
        && $past(link_ok, 3) && $past(!sys_rst, 4) |=> {setpoint_ext, setpoint}
        == $past(out_image[12:0]) || {setpoint_ext, setpoint}
        == {$past(out_image[4:0]), $past(out_image[15:8])})
        else $error("setpoint does not follow received word");
    a_sp_cause: assert property ($changed({setpoint_ext, setpoint}) |-> $past(out_valid)
        || !$past(link_ok, 2) || !$past(link_ok, 3) || !$past(link_ok, 4))
        else $error("setpoint changed without cause");
    a_compat_boot: assert property ($changed(legacy_mode) |-> ##[0:1] reboot_req)
        else $error("compatibility change without reboot");
    a_boot_len: assert property ($fell(reboot_req) |-> boot_cnt == reboot_cycles)
        else $error("reboot pulse length wrong");
    a_fb_upper: assert property (in_image[15:13] == 3'h0 || in_image[7:5] == 3'h0)
        else $error("feedback filler bits not zero");
    a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped");
    a_r_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
endmodule : pd_map_sva

bind pd_map pd_map_sva pd_map_sva_i (.*);

// [pd_ctrl_model.sv]
`timescale 1ns/1ps
// network controller side: sends setpoint words, owns the link level
module pd_ctrl_model
(
    input wire logic clk_sys,
    output logic [15:0] out_image,
    output logic out_valid,
    output logic link_ok
);
    // idle: no word, link down
    initial
    begin
        out_image = 16'h0;
        out_valid = 1'b0;
        link_ok = 1'b0;
    end
    // one word, filler bits 13..15 sent as 101 so they must be ignored
    task automatic send(input logic [11:0] v, input logic ext, input logic swap);
        logic [15:0] w;
        w = {3'h5, ext, v};
        @(posedge clk_sys);
        out_image <= swap ? {w[7:0], w[15:8]} : w;
        out_valid <= 1'b1;
        @(posedge clk_sys);
        out_valid <= 1'b0;
        out_image <= ~out_image; // no stale word after release
    endtask : send
    // connection level
    task automatic set_link(input logic up);
        link_ok <= up;
    endtask : set_link
endmodule : pd_ctrl_model

// [regulator_process_data_mapper_test.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module regulator_process_data_mapper_test
    import pd_map_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] out_image;
    logic out_valid, link_ok, setpoint_ext, reboot_req, legacy_mode, irq;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
    logic [31:0] s_wdata = 32'h0, in_image, s_rdata;
    logic [3:0] s_wstrb = 4'hf;
    logic [11:0] setpoint;
    logic [1:0] s_bresp, s_rresp;
    int fail_count = 0;
    int n_checks = 0;
    pd_map pd_map_i (.*);
    pd_ctrl_model pd_ctrl_model_i (.*);
    always #2.5 clk_sys = ~clk_sys;
    // verdict and end of run
    task automatic test_done();
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // bus write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_awaddr <= a;
        s_wdata <= dat;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        while (aw || w)
        begin
            @(posedge clk_sys);
            if (s_awready) aw = 1'b0;
            if (s_wready) w = 1'b0;
            s_awvalid <= aw;
            s_wvalid <= w;
        end
        do @(posedge clk_sys); while (!s_bvalid);
        s_bready <= 1'b1; // late ready: response must stand
        do @(posedge clk_sys); while (!s_bvalid);
        rsp = s_bresp;
        s_bready <= 1'b0;
    endtask : wr
    // bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do @(posedge clk_sys); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_rvalid);
        s_rready <= 1'b1; // late ready: data must stand
        do @(posedge clk_sys); while (!s_rvalid);
        dat = s_rdata;
        rsp = s_rresp;
        s_rready <= 1'b0;
    endtask : rd
    // watchdog
    initial
    begin
        #100000;
        fail_count++;
        test_done();
    end
    // main sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(ctrl_off, d, r);
        `CHK("ctrl", 32'h0, d)
        wr(8'h1c, 32'h0, r);
        `CHK("wr_unmapped", resp_slverr, r)
        pd_ctrl_model_i.set_link(1'b1);
        repeat (4) @(posedge clk_sys);
        for (int s = 0; s < 2; s++)
        begin
            wr(ctrl_off, 32'(s), r);
            pd_ctrl_model_i.send(12'(4095 - s), 1'b1, s[0]);
            repeat (2) @(posedge clk_sys);
            `CHK("sp", {1'b1, 12'(4095 - s)}, {setpoint_ext, setpoint})
            wr(feedback_off, 32'hfabc, r);
            wr(diag_off, 32'h1234, r);
            `CHK("img", s ? 32'h3412bc1a : 32'h12341abc, in_image)
        end
        wr(ctrl_off, 32'h2, r);
        pd_ctrl_model_i.send(12'h5a5, 1'b0, 1'b0);
        pd_ctrl_model_i.set_link(1'b0);
        repeat (6) @(posedge clk_sys);
        `CHK("held", 12'h5a5, setpoint)
        rd(setpoint_off, d, r);
        `CHK("sp_rd", 32'h0000_05a5, d)
        wr(mask_off, 32'(1 << ev_loss_bit), r);
        `CHK("irq_set", 1'b1, irq)
        wr(status_off, 32'(1 << ev_loss_bit), r);
        `CHK("irq_clr", 1'b0, irq)
        pd_ctrl_model_i.set_link(1'b1);
        repeat (4) @(posedge clk_sys);
        wr(ctrl_off, 32'h0, r);
        pd_ctrl_model_i.send(12'h123, 1'b1, 1'b0);
        pd_ctrl_model_i.set_link(1'b0);
        repeat (4) @(posedge clk_sys);
        `CHK("dropped", 12'h0, setpoint)
        `CHK("irq_loss", 1'b1, irq)
        wr(ctrl_off, 32'h4, r); // compatibility alone
        `CHK("legacy", 1'b1, legacy_mode)
        `CHK("boot", 1'b1, reboot_req)
        `CHK("legacy_img", 32'h3412bc1a, in_image)
        repeat (20) @(posedge clk_sys);
        `CHK("boot_end", 1'b0, reboot_req)
        rd(status_off, d, r);
        `CHK("status", 32'h0000_0007, d)
        `CHK("status_resp", resp_okay, r)
        test_done();
    end
endmodule : regulator_process_data_mapper_test
